// ### rtl/pib_en_reg.sv
// one peripheral interrupt enable register with a mask of implemented bits
`timescale 1ns/1ps
module pib_en_reg #(
  parameter logic [7:0] IMPL_MASK = 8'hff
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       wr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] value
);
  import pib_pkg::*;

  pib_en_state_t s_q;
  pib_en_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (wr) begin
      s_d.en = wdata & IMPL_MASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= EN_STATE_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign value = s_q.en;

endmodule : pib_en_reg

// ### rtl/pib_irq_bank.sv
// peripheral interrupt enable bank with avalon slave and interrupt output
//
// Behaviour
// - no peripheral source reaches the core unless peripheral master enable set.
// - enable bit 7 gates the oscillator failure interrupt.
// - enable bit 6 gates the comparator two interrupt.
// - enable bit 5 gates the comparator one interrupt.
// - enable bit 4 gates the nonvolatile write done interrupt.
// - enable bit 3 gates the serial port one collision interrupt.
// - enable bits 2 and 1 read zero and ignore writes.
// - enable bit 0 gates capture/compare two, large variant only.
// - implemented enable bits are read/write and clear on every reset.
// - third enable register exists on large variant, under master enable.
// - global enable passes all active interrupts or blocks all of them.
// - pending flags set regardless of enables; software clears before enabling.
`timescale 1ns/1ps
module pib_irq_bank #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  input  wire logic                          ce,
  input  wire logic [pib_pkg::ADDR_W-1:0]    avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [pib_pkg::DATA_W-1:0]    avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic      [pib_pkg::DATA_W-1:0]    avs_readdata,
  output logic                               avs_waitrequest,
  input  wire logic [pib_pkg::SRC_W-1:0]     ev_two,
  input  wire logic [pib_pkg::SRC_W-1:0]     ev_three,
  output logic                               irq
);
  import pib_pkg::*;

  localparam logic [7:0]  TWO_MASK   = LARGE_VARIANT ? EN_TWO_MASK_LRG
                                                     : EN_TWO_MASK_SML;
  localparam logic [7:0]  THREE_MASK = LARGE_VARIANT ? EN_THREE_MASK
                                                     : EN_RST;
  localparam logic [15:0] FLAG_MASK  = {THREE_MASK, TWO_MASK};

  pib_top_state_t s_q;
  pib_top_state_t s_d;

  logic        req;
  logic        ack;
  logic        wr_lo;
  logic        wr_two;
  logic        wr_three;
  logic [7:0]  en_two;
  logic [7:0]  en_three;
  logic [7:0]  src_two;
  logic [7:0]  src_three;
  logic        any_src;
  logic [31:0] rd_mux;
  logic [15:0] rd_clear;

  // a request completes on the edge where waitrequest is already low
  assign req      = avs_read | avs_write;
  assign ack      = req & ~s_q.waitreq;
  assign wr_lo    = ack & avs_write & avs_byteenable[0];
  assign wr_two   = wr_lo & (avs_address == OFS_EN_TWO);
  assign wr_three = wr_lo & (avs_address == OFS_EN_THREE) & LARGE_VARIANT;

  pib_en_reg #(
    .IMPL_MASK (TWO_MASK)
  ) u_en_two (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .wr      (wr_two),
    .wdata   (avs_writedata[7:0]),
    .value   (en_two)
  );

  pib_en_reg #(
    .IMPL_MASK (THREE_MASK)
  ) u_en_three (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .wr      (wr_three),
    .wdata   (avs_writedata[7:0]),
    .value   (en_three)
  );

  // per-source gating of pending flag by its enable bit
  always_comb begin
    src_two                  = 8'h00;
    src_two[BIT_OSF]         = s_q.status[BIT_OSF] & en_two[BIT_OSF];
    src_two[BIT_CMP_TWO]     = s_q.status[BIT_CMP_TWO]
                               & en_two[BIT_CMP_TWO];
    src_two[BIT_CMP_ONE]     = s_q.status[BIT_CMP_ONE]
                               & en_two[BIT_CMP_ONE];
    src_two[BIT_NV_WRITE]    = s_q.status[BIT_NV_WRITE]
                               & en_two[BIT_NV_WRITE];
    src_two[BIT_COLLISION]   = s_q.status[BIT_COLLISION]
                               & en_two[BIT_COLLISION];
    src_two[BIT_CAPCOMP_TWO] = s_q.status[BIT_CAPCOMP_TWO]
                               & en_two[BIT_CAPCOMP_TWO];
    src_three                = s_q.status[15:8] & en_three;
    any_src                  = |{src_two, src_three};
  end

  // read mux; unmapped and misaligned addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      OFS_EN_TWO:   rd_mux[7:0]  = en_two;
      OFS_EN_THREE: rd_mux[7:0]  = en_three;
      OFS_CTRL:     rd_mux[7:0]  = s_q.ctrl;
      OFS_STATUS:   rd_mux[15:0] = s_q.status;
      default:      rd_mux       = 32'h0000_0000;
    endcase
  end

  // clear only the bits the completing read actually returned
  assign rd_clear = (ack & avs_read & (avs_address == OFS_STATUS))
                    ? s_q.readdata[15:0] : 16'h0000;

  always_comb begin
    s_d = s_q;
    s_d.waitreq = ~(req & s_q.waitreq);
    if (req && s_q.waitreq && avs_read) begin
      s_d.readdata = rd_mux;
    end
    if (wr_lo && (avs_address == OFS_CTRL)) begin
      s_d.ctrl = avs_writedata[7:0] & CTRL_MASK;
    end
    // set beats clear so an event in the clearing cycle survives
    s_d.status = (s_q.status & ~rd_clear) | ({ev_three, ev_two} & FLAG_MASK);
    s_d.irq = s_q.ctrl[BIT_GIE] & s_q.ctrl[BIT_PME] & any_src;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= TOP_STATE_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign avs_readdata    = s_q.readdata;
  assign avs_waitrequest = s_q.waitreq;
  assign irq             = s_q.irq;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  logic gate_on;
  assign gate_on = s_q.ctrl[BIT_GIE] & s_q.ctrl[BIT_PME];

  property p_src(int b);
    ce && gate_on && s_q.status[b] && en_two[b] |=> irq;
  endproperty

  AST_PME_BLOCKS: assert property (
    ce && !s_q.ctrl[BIT_PME] |=> !irq)
    else $error("irq high with peripheral master enable clear");
  AST_GIE_BLOCKS: assert property (
    ce && !s_q.ctrl[BIT_GIE] |=> !irq)
    else $error("irq high with global enable clear");
  AST_REQ_EQN: assert property (
    ce |=> irq == $past(gate_on & any_src))
    else $error("irq does not follow flag and enable terms");
  AST_OSF_GATE: assert property (p_src(BIT_OSF))
    else $error("oscillator failure not passed");
  AST_CMP2_GATE: assert property (p_src(BIT_CMP_TWO))
    else $error("comparator two not passed");
  AST_CMP1_GATE: assert property (p_src(BIT_CMP_ONE))
    else $error("comparator one not passed");
  AST_NVW_GATE: assert property (p_src(BIT_NV_WRITE))
    else $error("nonvolatile write done not passed");
  AST_COL_GATE: assert property (p_src(BIT_COLLISION))
    else $error("serial collision not passed");
  AST_CCP_GATE: assert property (
    ce && gate_on && s_q.status[BIT_CAPCOMP_TWO]
    && en_two[BIT_CAPCOMP_TWO] |=> irq == LARGE_VARIANT)
    else $error("capture compare two gating wrong");
  AST_UNIMPL_ZERO: assert property (
    en_two[2:1] == 2'b00 && (en_three & ~THREE_MASK) == 8'h00)
    else $error("unimplemented enable bit set");
  AST_RESET_CLEAR: assert property (
    $past(rst) |-> en_two == EN_RST && en_three == EN_RST
    && s_q.ctrl == CTRL_RST && !irq)
    else $error("enable state not cleared by reset");
  AST_WRITE_TWO: assert property (
    ce && wr_two |=> en_two == ($past(avs_writedata[7:0]) & TWO_MASK))
    else $error("enable two write not stored");
  AST_FLAG_SET: assert property (
    ce && ev_two[BIT_OSF] |=> s_q.status[BIT_OSF])
    else $error("pending flag not set by event");
  AST_WAIT_ONE: assert property (
    ce && req && s_q.waitreq ##1 ce
    |-> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest handshake wrong");

  // bus handshake and read path
  AST_WAIT_IDLE: assert property (
    ce && !req |=> avs_waitrequest)
    else $error("waitrequest low without a request");
  AST_WAIT_LOW_ONE: assert property (
    ce && !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_RD_EN_TWO: assert property (
    ce && req && s_q.waitreq && avs_read && avs_address == OFS_EN_TWO
    |=> avs_readdata == {24'h00_0000, $past(en_two)})
    else $error("enable two read back wrong");
  AST_RD_CTRL: assert property (
    ce && req && s_q.waitreq && avs_read && avs_address == OFS_CTRL
    |=> avs_readdata == {24'h00_0000, $past(s_q.ctrl)})
    else $error("control read back wrong");
  AST_RD_STATUS: assert property (
    ce && req && s_q.waitreq && avs_read && avs_address == OFS_STATUS
    |=> avs_readdata == {16'h0000, $past(s_q.status)})
    else $error("status read back wrong");
  AST_RD_UNMAPPED: assert property (
    ce && req && s_q.waitreq && avs_read
    && (avs_address[4] || avs_address[1:0] != 2'b00)
    |=> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_RD_UPPER: assert property (
    avs_readdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  AST_RD_HOLD: assert property (
    ce && !(req && s_q.waitreq && avs_read) |=> $stable(avs_readdata))
    else $error("read data changed without a read");

  // register writes, holds, freeze and reset
  AST_WRITE_THREE: assert property (
    ce && wr_three |=> en_three == ($past(avs_writedata[7:0]) & THREE_MASK))
    else $error("enable three write not stored");
  AST_WRITE_CTRL: assert property (
    ce && wr_lo && avs_address == OFS_CTRL
    |=> s_q.ctrl == ($past(avs_writedata[7:0]) & CTRL_MASK))
    else $error("control write not stored");
  AST_TWO_HOLD: assert property (
    ce && !wr_two |=> $stable(en_two))
    else $error("enable two changed without a write");
  AST_NO_ACK_HOLD: assert property (
    ce && !ack |=> $stable(s_q.ctrl) && $stable(en_three))
    else $error("control or enable three changed without a write");
  AST_BE_IGNORED: assert property (
    ce && ack && avs_write && !avs_byteenable[0]
    |=> $stable(en_two) && $stable(en_three) && $stable(s_q.ctrl))
    else $error("write without byte lane zero landed");
  AST_CE_FREEZE: assert property (
    !ce |=> $stable(s_q) && $stable(en_two) && $stable(en_three))
    else $error("state moved while clock enable low");
  AST_RESET_REGS: assert property (
    $past(rst) |-> s_q.status == STATUS_RST && avs_waitrequest
    && avs_readdata == RDATA_RST)
    else $error("bus or flag state not cleared by reset");

  // pending flags and request
  AST_FLAG_ANY: assert property (
    ce |=> (s_q.status & $past({ev_three, ev_two} & FLAG_MASK))
    == $past({ev_three, ev_two} & FLAG_MASK))
    else $error("event did not set its pending flag");
  AST_FLAG_STICKY: assert property (
    ce && rd_clear == 16'h0000
    |=> (s_q.status & $past(s_q.status)) == $past(s_q.status))
    else $error("pending flag lost without a status read");
  AST_READ_CLEAR: assert property (
    ce && rd_clear != 16'h0000 && ev_two == 8'h00 && ev_three == 8'h00
    |=> (s_q.status & $past(rd_clear)) == 16'h0000)
    else $error("status read did not clear returned flags");
  AST_STATUS_IMPL: assert property (
    (s_q.status & ~FLAG_MASK) == 16'h0000)
    else $error("unimplemented flag bit set");
  AST_THREE_GATE: assert property (
    ce && gate_on && (|(s_q.status[15:8] & en_three)) |=> irq)
    else $error("enable three source not passed");
  AST_NO_SRC: assert property (
    ce && !any_src |=> !irq)
    else $error("irq high with no enabled pending flag");
  AST_NO_ENABLE: assert property (
    ce && en_two == 8'h00 && en_three == 8'h00 |=> !irq)
    else $error("irq high with every enable clear");

  // a lone pending flag with its enable clear must stay silent
  property p_block(int b);
    ce && !en_two[b] && s_q.status == (16'h0001 << b) |=> !irq;
  endproperty

  AST_OSF_BLOCK: assert property (p_block(BIT_OSF))
    else $error("oscillator failure passed while disabled");
  AST_CMP2_BLOCK: assert property (p_block(BIT_CMP_TWO))
    else $error("comparator two passed while disabled");
  AST_CMP1_BLOCK: assert property (p_block(BIT_CMP_ONE))
    else $error("comparator one passed while disabled");
  AST_NVW_BLOCK: assert property (p_block(BIT_NV_WRITE))
    else $error("nonvolatile write done passed while disabled");
  AST_COL_BLOCK: assert property (p_block(BIT_COLLISION))
    else $error("serial collision passed while disabled");
  AST_CCP_BLOCK: assert property (p_block(BIT_CAPCOMP_TWO))
    else $error("capture compare two passed while disabled");

  CVR_IRQ_RISE: cover property (ce && !irq ##1 irq);
  CVR_READ_CLEAR: cover property (ack && avs_read
    && avs_address == OFS_STATUS && s_q.readdata[15:0] != 16'h0000);
  CVR_WRITE_TWO: cover property (wr_two && avs_writedata[7:0] == 8'hff);
  CVR_SET_WINS: cover property (rd_clear[BIT_OSF] && ev_two[BIT_OSF]);
  CVR_THREE_IRQ: cover property (ce && gate_on
    && (|(s_q.status[15:8] & en_three)));

endmodule : pib_irq_bank

// ### rtl/pib_pkg.sv
// package: offsets, field layout, reset values and state types of the block
package pib_pkg;

  localparam int            ADDR_W           = 5;
  localparam int            DATA_W           = 32;
  localparam int            SRC_W            = 8;

  localparam logic [4:0]    OFS_EN_TWO       = 5'h00;
  localparam logic [4:0]    OFS_EN_THREE     = 5'h04;
  localparam logic [4:0]    OFS_CTRL         = 5'h08;
  localparam logic [4:0]    OFS_STATUS       = 5'h0c;

  localparam int            BIT_OSF          = 7;
  localparam int            BIT_CMP_TWO      = 6;
  localparam int            BIT_CMP_ONE      = 5;
  localparam int            BIT_NV_WRITE     = 4;
  localparam int            BIT_COLLISION    = 3;
  localparam int            BIT_CAPCOMP_TWO  = 0;
  localparam int            BIT_GIE          = 7;
  localparam int            BIT_PME          = 6;

  localparam logic [7:0]    EN_TWO_MASK_SML  = 8'hf8;
  localparam logic [7:0]    EN_TWO_MASK_LRG  = 8'hf9;
  localparam logic [7:0]    EN_THREE_MASK    = 8'h3a;
  localparam logic [7:0]    CTRL_MASK        = 8'hc0;
  localparam logic [7:0]    EN_RST           = 8'h00;
  localparam logic [7:0]    CTRL_RST         = 8'h00;
  localparam logic [15:0]   STATUS_RST       = 16'h0000;
  localparam logic [31:0]   RDATA_RST        = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] en;
  } pib_en_state_t;

  typedef struct packed {
    logic [7:0]  ctrl;
    logic [15:0] status;
    logic [31:0] readdata;
    logic        waitreq;
    logic        irq;
  } pib_top_state_t;

  localparam pib_en_state_t  EN_STATE_RST  = '{en: EN_RST};
  localparam pib_top_state_t TOP_STATE_RST = '{
    ctrl:     CTRL_RST,
    status:   STATUS_RST,
    readdata: RDATA_RST,
    waitreq:  1'b1,
    irq:      1'b0
  };

endpackage : pib_pkg

// ### verif/peripheral_irq_enable_bank_two_tb.sv
// self-checking bench for the peripheral interrupt enable bank
`timescale 1ns/1ps
module peripheral_irq_enable_bank_two_tb;
  import pib_pkg::*;
  logic              clk_sys;
  logic              rst;
  logic              ce;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [DATA_W-1:0] avs_writedata;
  logic [3:0]        avs_byteenable;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic [SRC_W-1:0]  ev_two;
  logic [SRC_W-1:0]  ev_three;
  logic              irq;
  int                error_cnt;
  int                checks;
  int                cyc = 0;
  logic [31:0]       q;
  logic [31:0]       x;
  logic [7:0]        e2, e3, c, f2, f3;

  pib_irq_bank #(.LARGE_VARIANT(1'b1)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ev_two(ev_two), .ev_three(ev_three), .irq(irq));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic end_sim();
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  task automatic cmp_irq(input logic exp, input string what);
    checks++;
    if (irq !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s got %b exp %b", $time, what, irq, exp);
    end
  endtask : cmp_irq

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  // master holds the request until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [7:0] d, input logic be,
                     output logic [31:0] rd);
    @(posedge clk_sys);
    avs_address    <= a;
    avs_writedata  <= {24'h00_0000, d};
    avs_byteenable <= {3'h0, be};
    avs_read       <= ~w;
    avs_write      <= w;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  function automatic logic exp_irq(logic [7:0] ct, a2, a3, s2, s3);
    return ct[BIT_GIE] & ct[BIT_PME] &
           (|((a2 & s2 & EN_TWO_MASK_LRG) | (a3 & s3 & EN_THREE_MASK)));
  endfunction : exp_irq

  // cuts a hung run short
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  initial begin
    rst            = 1'b1;
    ce             = 1'b1;
    avs_address    = '0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = '0;
    avs_byteenable = 4'h0;
    ev_two         = '0;
    ev_three       = '0;
    error_cnt      = 0;
    checks         = 0;
    void'($urandom(32'h890e));
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    for (int a = 0; a < 16; a += 4) begin
      bus(1'b0, 5'(a), 8'h00, 1'b1, q);
      cmp(q, 32'h0, "reset value");
    end
    // refused places: status write, unmapped and misaligned reads
    bus(1'b1, OFS_STATUS, 8'hff, 1'b1, q);
    bus(1'b0, OFS_STATUS, 8'h00, 1'b1, q);
    cmp(q, 32'h0, "status write");
    bus(1'b0, 5'h10, 8'h00, 1'b1, q);
    cmp(q, 32'h0, "unmapped read");
    bus(1'b0, 5'h01, 8'h00, 1'b1, q);
    cmp(q, 32'h0, "misaligned read");
    // all ones, then a write without byte lane zero must not land
    bus(1'b1, OFS_EN_TWO, 8'hff, 1'b1, q);
    bus(1'b1, OFS_EN_TWO, 8'h00, 1'b0, q);
    bus(1'b0, OFS_EN_TWO, 8'h00, 1'b1, q);
    cmp(q, 32'(EN_TWO_MASK_LRG), "enable two mask");
    for (int i = 0; i < 40; i++) begin
      e2 = (i == 0) ? 8'hff : 8'($urandom);
      e3 = 8'($urandom);
      c  = (i < 4) ? 8'(i << 6) : 8'($urandom);
      f2 = (i < 8) ? 8'h80 >> i : 8'($urandom) & 8'($urandom);
      f3 = (i < 8) ? 8'h00 : 8'($urandom) & 8'($urandom);
      bus(1'b1, OFS_EN_TWO, e2, 1'b1, q);
      bus(1'b1, OFS_EN_THREE, e3, 1'b1, q);
      bus(1'b1, OFS_CTRL, c, 1'b1, q);
      bus(1'b0, OFS_EN_TWO, 8'h00, 1'b1, q);
      cmp(q, 32'(e2 & EN_TWO_MASK_LRG), "enable two");
      bus(1'b0, OFS_EN_THREE, 8'h00, 1'b1, q);
      cmp(q, 32'(e3 & EN_THREE_MASK), "enable three");
      bus(1'b0, OFS_CTRL, 8'h00, 1'b1, q);
      cmp(q, 32'(c & CTRL_MASK), "control");
      // clear stale flags before the events
      bus(1'b0, OFS_STATUS, 8'h00, 1'b1, q);
      @(posedge clk_sys);
      ev_two   <= f2;
      ev_three <= f3;
      @(posedge clk_sys);
      ev_two   <= '0;
      ev_three <= '0;
      repeat (2) @(posedge clk_sys);
      x[0] = exp_irq(c, e2, e3, f2, f3);
      cmp_irq(x[0], "irq");
      bus(1'b0, OFS_STATUS, 8'h00, 1'b1, q);
      x = {16'h0, f3 & EN_THREE_MASK, f2 & EN_TWO_MASK_LRG};
      cmp(q, x, "flags");
      repeat (2) @(posedge clk_sys);
      cmp_irq(1'b0, "irq after clear");
    end
    // events with clock enable low must leave the flags alone
    @(posedge clk_sys);
    ce     <= 1'b0;
    ev_two <= 8'hff;
    @(posedge clk_sys);
    ce     <= 1'b1;
    ev_two <= 8'h00;
    bus(1'b0, OFS_STATUS, 8'h00, 1'b1, q);
    cmp(q, 32'h0, "flags with clock enable low");
    // a second reset in mid-run clears the enables again
    bus(1'b1, OFS_EN_TWO, 8'hff, 1'b1, q);
    bus(1'b1, OFS_CTRL, 8'hc0, 1'b1, q);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    bus(1'b0, OFS_EN_TWO, 8'h00, 1'b1, q);
    cmp(q, 32'h0, "enable two after reset");
    bus(1'b0, OFS_CTRL, 8'h00, 1'b1, q);
    cmp(q, 32'h0, "control after reset");
    end_sim();
  end
endmodule : peripheral_irq_enable_bank_two_tb
